//--- hw/adc_conversion_control.sv
`default_nettype none
module adc_conversion_control (
  input  wire logic                                         clk,
  input  wire logic                                         rst_n,
  input  wire logic                                         ce,
  input  wire logic                                         ctl_wr,
  input  wire logic [7:0]                                   ctl_wdata,
  input  wire logic                                         res_wr,
  input  wire logic [7:0]                                   res_wdata,
  input  wire logic                                         ref_wr,
  input  wire logic [7:0]                                   ref_wdata,
  input  wire logic                                         comp_above,
  output logic [7:0]                                        ctl_rdata,
  output logic [7:0]                                        conversion_result_reg,
  output logic [7:0]                                        reference_program_reg,
  output logic                                              conversion_busy_flag,
  output logic                                              sample_enable,
  output logic [adc_conversion_control_pkg::CHAN_W-1:0]     mux_channel,
  output logic [adc_conversion_control_pkg::DATA_W-1:0]     trial_code,
  output adc_conversion_control_pkg::ref_setting_t          reference_setting
);

  adc_conversion_control_pkg::conv_ctl_t    ctl_reg;
  adc_conversion_control_pkg::conv_ctl_t    ctl_next;
  adc_conversion_control_pkg::conv_state_t  state_reg;
  adc_conversion_control_pkg::conv_state_t  state_next;
  adc_conversion_control_pkg::ref_setting_t ref_set_next;
  logic [adc_conversion_control_pkg::CYC_W-1:0]  cyc_reg;
  logic [adc_conversion_control_pkg::CYC_W-1:0]  cyc_next;
  logic [adc_conversion_control_pkg::DATA_W-1:0] sar_reg;
  logic [adc_conversion_control_pkg::DATA_W-1:0] sar_next;
  logic [adc_conversion_control_pkg::DATA_W-1:0] trial_bit;
  logic [adc_conversion_control_pkg::DATA_W-1:0] next_bit;
  logic [7:0] result_next;
  logic [7:0] ref_next;
  logic       busy_next;
  logic       sample_next;
  logic       start;
  logic       in_step;
  logic       storing;
  logic       restart;
  logic       chan_next_cont;
  logic [2:0] step_idx;

  // a reference write is the only start source from software
  // a write in mid-conversion simply reloads the sequencer, so software
  // never has to wait for busy to drop before picking new references;
  // the price is that the partial result of the aborted run is lost
  // start on write
  assign start   = ce & ref_wr;
  assign in_step = (state_reg == adc_conversion_control_pkg::ST_APPROX) &
                   (cyc_reg >= adc_conversion_control_pkg::CYC_STEP_FIRST) &
                   (cyc_reg <= adc_conversion_control_pkg::CYC_STEP_LAST);
  assign storing = ce & (state_reg == adc_conversion_control_pkg::ST_APPROX) &
                   (cyc_reg == adc_conversion_control_pkg::CYC_STORE);
  // continuous auto restart
  // the continuous bit is read from the register, not the write data, so a
  // control write landing on the store edge only takes effect on the next run
  assign restart = start | (storing & ctl_reg.continuous);

  // bit under test: msb in the first step, lsb in the eighth
  // step_idx counts down from the last step cycle, so the decode stays
  // valid only inside the step window; outside it in_step masks the result
  assign step_idx  = 3'(adc_conversion_control_pkg::CYC_STEP_LAST - cyc_reg);
  assign trial_bit = 8'h01 << step_idx;
  assign next_bit  = (step_idx == 3'h0) ? 8'h00 : (trial_bit >> 1);

  assign chan_next_cont = ctl_wdata[adc_conversion_control_pkg::CTL_CONT_BIT];
  assign ctl_next = (ce & ctl_wr) ?
    {chan_next_cont,
     ctl_wdata[adc_conversion_control_pkg::CTL_CHAN_LSB +: adc_conversion_control_pkg::CHAN_W]} :
    ctl_reg;

  // sequencer: sample cycles 1..5, steps 6..13, settle 14, store 15
  // cycle 14 is left idle so the last decision has a full machine cycle
  // to reach the register before the store; restart has priority over
  // every state so a write always begins again at cycle 1
  always_comb begin
    state_next = state_reg;
    cyc_next   = cyc_reg;
    if (restart) begin
      state_next = adc_conversion_control_pkg::ST_SAMPLE;
      cyc_next   = adc_conversion_control_pkg::CYC_FIRST;
    end else if (ce) begin
      case (state_reg)
        adc_conversion_control_pkg::ST_IDLE: begin
          cyc_next = '0;
        end
        adc_conversion_control_pkg::ST_SAMPLE: begin
          cyc_next = cyc_reg + 4'h1;
          if (cyc_reg == adc_conversion_control_pkg::CYC_SAMPLE_LAST) begin
            state_next = adc_conversion_control_pkg::ST_APPROX;
          end
        end
        adc_conversion_control_pkg::ST_APPROX: begin
          if (cyc_reg == adc_conversion_control_pkg::CYC_STORE) begin
            state_next = adc_conversion_control_pkg::ST_IDLE;
            cyc_next   = '0;
          end else begin
            cyc_next = cyc_reg + 4'h1;
          end
        end
        default: begin
          state_next = adc_conversion_control_pkg::ST_IDLE;
          cyc_next   = '0;
        end
      endcase
    end
  end

  // trial code: keep the tested bit if the input is above it, then try the next
  // the comparator is assumed settled one machine cycle after the trial code
  // changes; a slower analog path would need extra settle cycles per step
  // one bit per step
  always_comb begin
    sar_next = sar_reg;
    if (restart) begin
      sar_next = '0;
    end else if (ce & (state_next == adc_conversion_control_pkg::ST_APPROX) &
                 (cyc_next == adc_conversion_control_pkg::CYC_STEP_FIRST)) begin
      sar_next = 8'h80;
    end else if (ce & in_step) begin
      sar_next = (comp_above ? sar_reg : (sar_reg & ~trial_bit)) | next_bit;
    end
  end

  // hardware store wins over a software write in the same cycle
  // limitation: software storage in the result register is clobbered by
  // any conversion, so it is only usable while no reference write occurs
  // hold until overwritten
  assign result_next = storing ? sar_reg :
                       (ce & res_wr) ? res_wdata : conversion_result_reg;

  assign busy_next = restart ? 1'b1 :
                     storing ? 1'b0 : conversion_busy_flag;

  // input tracks the selected channel only while sampling; held afterwards
  // derived from the next state so the hold starts on the same edge that
  // enters the step phase, not one machine cycle late
  assign sample_next = (state_next == adc_conversion_control_pkg::ST_SAMPLE);

  // zero means external refs
  // the split is registered with the value itself, so the analog side never
  // sees a reference change without the matching start of a conversion
  assign ref_next     = start ? ref_wdata : reference_program_reg;
  assign ref_set_next = '{upper_code: ref_next[7:4],
                          lower_code: ref_next[3:0],
                          external:   (ref_next == adc_conversion_control_pkg::REF_EXTERNAL)};

  // all state frozen while ce is low, so ce acts as the machine-cycle strobe
  // every next value already holds its register when ce is low, so the
  // gating lives in the decode; only sample_enable adds a ce select here
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctl_reg               <= adc_conversion_control_pkg::conv_ctl_t'(
                                 adc_conversion_control_pkg::CTL_RESET[3:0]);
      state_reg             <= adc_conversion_control_pkg::ST_IDLE;
      cyc_reg               <= '0;
      sar_reg               <= '0;
      conversion_result_reg <= adc_conversion_control_pkg::RES_RESET;
      reference_program_reg <= adc_conversion_control_pkg::REF_RESET;
      conversion_busy_flag  <= 1'b0;
      sample_enable         <= 1'b0;
    end else begin
      ctl_reg               <= ctl_next;
      state_reg             <= state_next;
      cyc_reg               <= cyc_next;
      sar_reg               <= sar_next;
      conversion_result_reg <= result_next;
      reference_program_reg <= ref_next;
      conversion_busy_flag  <= busy_next;
      sample_enable         <= ce ? sample_next : sample_enable;
    end
  end

  // output copies registered so every pin comes from a flop
  // loaded from the next values so the copies never lag their registers,
  // which keeps readback of busy and channel aligned with the state
  // channel to mux
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mux_channel       <= '0;
      trial_code        <= '0;
      reference_setting <= '{upper_code: 4'h0, lower_code: 4'h0, external: 1'b1};
      ctl_rdata         <= adc_conversion_control_pkg::CTL_RESET;
    end else begin
      mux_channel       <= ctl_next.channel;
      trial_code        <= sar_next;
      reference_setting <= ref_set_next;
      ctl_rdata         <= {3'h0, busy_next, ctl_next.continuous, ctl_next.channel};
    end
  end

endmodule // adc_conversion_control
`default_nettype wire

//--- shared/adc_conversion_control_pkg.sv
`default_nettype none
package adc_conversion_control_pkg;

  // converter width and channel count
  localparam int unsigned DATA_W  = 8;
  localparam int unsigned CHAN_W  = 3;
  localparam int unsigned CYC_W   = 4;

  // control register field positions
  localparam int unsigned CTL_CHAN_LSB = 0;
  localparam int unsigned CTL_CONT_BIT = 3;
  localparam int unsigned CTL_BUSY_BIT = 4;

  // reset values
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [7:0] RES_RESET = 8'h00;
  localparam logic [7:0] REF_RESET = 8'h00;
  localparam logic [7:0] REF_EXTERNAL = 8'h00;

  // conversion timing in machine cycles, counted from the start cycle
  localparam logic [CYC_W-1:0] CYC_FIRST       = 4'h1;
  localparam logic [CYC_W-1:0] CYC_SAMPLE_LAST = 4'h5;
  localparam logic [CYC_W-1:0] CYC_STEP_FIRST  = 4'h6;
  localparam logic [CYC_W-1:0] CYC_STEP_LAST   = 4'hd;
  localparam logic [CYC_W-1:0] CYC_STORE       = 4'hf;

  // conversion sequencer states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SAMPLE,
    ST_APPROX
  } conv_state_t;

  // software-visible control fields
  typedef struct packed {
    logic              continuous;
    logic [CHAN_W-1:0] channel;
  } conv_ctl_t;

  // reference settings driven to the analog macro
  typedef struct packed {
    logic [3:0] upper_code;
    logic [3:0] lower_code;
    logic       external;
  } ref_setting_t;

endpackage
`default_nettype wire

//--- bench/adc_conversion_control_checker.sv
`default_nettype none
module adc_conversion_control_checker (
  input wire logic                                 clk,
  input wire logic                                 rst_n,
  input wire logic                                 ce,
  input wire logic                                 ref_wr,
  input wire logic                                 res_wr,
  input wire logic [7:0]                           ctl_rdata,
  input wire logic [7:0]                           conversion_result_reg,
  input wire logic [7:0]                           reference_program_reg,
  input wire logic                                 conversion_busy_flag,
  input wire logic                                 sample_enable,
  input wire logic [2:0]                           mux_channel,
  input wire adc_conversion_control_pkg::ref_setting_t reference_setting
);
  logic [4:0] cnt_reg;
  logic [4:0] cnt_next;
  logic       restart;
  // machine cycle of the running conversion, saturating so idle time cannot wrap
  assign restart = ce && (ref_wr || (cnt_reg == 5'h0f && conversion_busy_flag && ctl_rdata[3]));
  assign cnt_next = restart ? 5'h01 : (ce && cnt_reg != 5'h1f) ? cnt_reg + 5'h01 : cnt_reg;
  always_ff @(posedge clk) cnt_reg <= rst_n ? cnt_next : 5'h00;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_busy_on_start: assert property (ce && ref_wr |=> conversion_busy_flag && sample_enable)
    else $error("busy not set by start");
  chk_sample_window: assert property (sample_enable == (conversion_busy_flag && cnt_reg >= 5'h01 && cnt_reg <= 5'h05))
    else $error("sample window wrong");
  chk_busy_clear: assert property ($fell(conversion_busy_flag) |-> cnt_reg == 5'h10)
    else $error("busy cleared at wrong cycle");
  chk_store_cycle: assert property ($changed(conversion_result_reg) && !$past(ce && res_wr) |-> cnt_reg == 5'h10 || cnt_reg == 5'h01)
    else $error("result stored at wrong cycle");
  chk_cont_restart: assert property (restart && !ref_wr |=> conversion_busy_flag && sample_enable)
    else $error("continuous mode did not restart");
  chk_busy_readback: assert property (ctl_rdata[4] == conversion_busy_flag)
    else $error("busy bit differs from flag");
  chk_mux_follow: assert property (mux_channel == ctl_rdata[2:0])
    else $error("mux channel differs from control");
  chk_ref_external: assert property (reference_setting.external == (reference_program_reg == 8'h00))
    else $error("external reference select wrong");
  chk_result_hold: assert property (!ce |=> $stable(conversion_result_reg))
    else $error("result moved while frozen");
  cover property (ce && ref_wr && conversion_busy_flag);
  cover property ($fell(conversion_busy_flag));
  cover property (restart && !ref_wr);
endmodule // adc_conversion_control_checker
`default_nettype wire

//--- bench/test_adc_conversion_control.sv
`default_nettype none
module test_adc_conversion_control;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1, ctl_wr = 1'b0, res_wr = 1'b0, ref_wr = 1'b0;
  logic [7:0] ctl_wdata = 8'h00, res_wdata = 8'h00, ref_wdata = 8'h00, target = 8'h00, v;
  logic [7:0] ctl_rdata, conversion_result_reg, reference_program_reg, trial_code;
  logic       conversion_busy_flag, sample_enable, busy_q = 1'b0;
  logic [2:0] mux_channel;
  adc_conversion_control_pkg::ref_setting_t reference_setting;
  logic [7:0] exp_q[$];
  int         n_fail = 0, tests_run = 0, cycles = 0;
  // comparator of an input sitting half a code above target
  wire comp_above = target >= trial_code;
  always #4 clk = ~clk;
  adc_conversion_control uut (.*);
  task automatic check(input string name, input logic [8:0] seen, input logic [8:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // sel 0 control, 1 result, 2 reference; settles one step past the taking edge
  task automatic wr(input int sel, input logic [7:0] d);
    @(posedge clk);
    {ctl_wr, res_wr, ref_wr} <= {sel == 0, sel == 1, sel == 2};
    {ctl_wdata, res_wdata, ref_wdata} <= {d, d, d};
    @(posedge clk);
    {ctl_wr, res_wr, ref_wr} <= 3'b000;
    #1;
  endtask
  task automatic wait_idle;
    for (int i = 0; i < 100 && conversion_busy_flag; i++) @(posedge clk);
    #1;
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // a store without a continuous restart shows as busy falling; compare against the oldest note
  always @(negedge clk) begin
    if (busy_q && !conversion_busy_flag && exp_q.size() > 0)
      check("result", conversion_result_reg, exp_q.pop_front());
    busy_q = conversion_busy_flag;
  end
  // hang guard, well above the expected run length
  always @(posedge clk) begin
    cycles++;
    if (cycles > 5000) begin
      n_fail++;
      summarize();
    end
  end
  initial begin
    void'($urandom(32'hdfbb6cf3));
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    check("ref_setting", reference_setting, 9'h001);
    check("control", ctl_rdata, 9'h000);
    for (int c = 0; c < 8; c++) begin
      wr(0, 8'(c));
      check("mux", mux_channel, 9'(c));
    end
    // strobes without machine-cycle enable must be ignored
    ce <= 1'b0;
    wr(0, 8'h0b);
    check("ctl_frozen", ctl_rdata, 9'h007);
    ce <= 1'b1;
    wr(1, 8'h5a);
    check("res_write", conversion_result_reg, 9'h05a);
    for (int i = 0; i < 4; i++) begin
      target = 8'($urandom);
      v = (i == 0) ? 8'h00 : 8'($urandom);
      wr(2, v);
      exp_q.push_back(target);
      check("ref_split", reference_setting, {v, v == 8'h00});
      check("ref_reg", reference_program_reg, {1'b0, v});
      wait_idle();
      check("trial", trial_code, {1'b0, target});
    end
    // restart in mid-conversion keeps only the second result
    target = 8'h3c;
    wr(2, 8'h00);
    repeat (7) @(posedge clk);
    #1;
    target = 8'hc3;
    wr(2, 8'h11);
    exp_q.push_back(8'hc3);
    wait_idle();
    wr(0, 8'h0d);
    target = 8'h99;
    wr(2, 8'h00);
    repeat (40) @(posedge clk);
    #1;
    check("cont_busy", conversion_busy_flag, 9'h001);
    wr(0, 8'h05);
    exp_q.push_back(8'h99);
    wait_idle();
    repeat (2) @(posedge clk);
    check("pending", 9'(exp_q.size()), 9'h000);
    summarize();
  end
endmodule // test_adc_conversion_control
bind adc_conversion_control adc_conversion_control_checker chk_i (.*);
`default_nettype wire
